// ===== float_led_pulse_sequencer.sv
// Float LED pulse sequencer with signed accumulator for two time slots.
// Contract
// - Fire decision per position comes from the slot fire mask, repeated every four.
// - Each pulse result is added or subtracted per the slot sign fields.
// - Accumulate over all pulses then make one final data write.
// - Source select equal to zero puts the slot in float mode.
// - Float enable equal to three lets the photodiode float between connects.
// - Sign one/two value 2 subtracts pulse one and adds pulse two.
// - Sign three/four value 1 adds pulse three and subtracts pulse four.
// - Cathode bias value 2 applies reverse bias during preconditioning.
// - Cathode override bit selects per-slot bias over the other register; the code drives bias 0 when it is clear.
// - Float LED choice selects none or one of three LEDs.
// - Photodiode is held in preconditioning for the precondition time first.
// - Float period is ten bits from low and high register fields, in us.
// - Connect width in us sets the charge dump time.
// - First float time is offset plus connect width minus precondition.
// - Fire mask bits are active low, lowest bit is the first pulse.
`timescale 1ns/1ps
module float_led_pulse_sequencer #(
	parameter int result_width = 27,
	parameter int sample_width = 14
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic reg_write,
	input wire logic [7:0] reg_address,
	input wire logic [15:0] reg_write_data,
	output logic [15:0] reg_read_data,
	input wire logic sample_start,
	input wire logic slot_b_select,
	input wire logic [sample_width-1:0] pulse_result,
	output logic [2:0] led_fire,
	output logic pd_connect,
	output logic pd_precondition,
	output logic [1:0] cathode_bias,
	output logic cathode_override,
	output logic integrate_strobe,
	output logic busy,
	output logic result_valid,
	output logic result_slot_b,
	output logic signed [result_width-1:0] result_data
);
	logic [15:0] regs [0:16];
	logic [15:0] next_regs [0:16];
	localparam logic [7:0] map [0:16] = '{float_led_pkg::addr_source_select,
		float_led_pkg::addr_a_pulse_timing, float_led_pkg::addr_a_period_low,
		float_led_pkg::addr_b_pulse_timing, float_led_pkg::addr_b_period_low,
		float_led_pkg::addr_period_high, float_led_pkg::addr_a_led_choice,
		float_led_pkg::addr_b_led_choice, float_led_pkg::addr_a_amp_reference,
		float_led_pkg::addr_a_analog_cfg, float_led_pkg::addr_b_amp_reference,
		float_led_pkg::addr_b_analog_cfg, float_led_pkg::addr_cathode_bias,
		float_led_pkg::addr_sign_control, float_led_pkg::addr_b_float_control,
		float_led_pkg::addr_fire_mask, float_led_pkg::addr_a_float_control};
	float_led_pkg::seq_state_type state, next_state;
	float_led_pkg::slot_cfg_type cfg, next_cfg, slot_a, slot_b;
	logic [15:0] timer, next_timer;
	logic [7:0] pulse_index, next_pulse_index;
	logic signed [result_width-1:0] accum, next_accum;
	logic signed [result_width-1:0] sample_ext;
	logic [1:0] position;
	logic subtract_here, first_pulse;
	logic [2:0] next_led_fire;
	logic next_result_valid, next_result_slot_b, result_slot;
	logic [15:0] first_float_us;

	// Register writes; every mapped register is a plain 16-bit store.
	always_comb begin
		for (int i = 0; i <= 16; i++) begin
			next_regs[i] = regs[i];
			if (reg_write && reg_address == map[i]) begin
				next_regs[i] = reg_write_data;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i <= 16; i++) begin
				regs[i] <= float_led_pkg::reg_reset;
			end
		end else begin
			regs <= next_regs;
		end
	end

	// Read decoding; unmapped addresses read as zero.
	always_comb begin
		reg_read_data = 16'h0000;
		for (int i = 0; i <= 16; i++) begin
			if (reg_address == map[i]) begin
				reg_read_data = regs[i];
			end
		end
	end

	// Per-slot field extraction from the shared and per-slot registers.
	always_comb begin
		slot_a.source = regs[0][1:0];
		slot_b.source = regs[0][3:2];
		slot_a.float_enable = regs[16][14:13];
		slot_b.float_enable = regs[14][14:13];
		slot_a.precondition_time = regs[16][12:8];
		slot_b.precondition_time = regs[14][12:8];
		slot_a.float_period = {regs[5][1:0], regs[2][7:0]};
		slot_b.float_period = {regs[5][9:8], regs[4][7:0]};
		slot_a.connect_width = regs[1][12:8];
		slot_b.connect_width = regs[3][12:8];
		slot_a.first_dump_offset = regs[1][7:0];
		slot_b.first_dump_offset = regs[3][7:0];
		slot_a.pulse_count = regs[2][15:8];
		slot_b.pulse_count = regs[4][15:8];
		slot_a.float_led_choice = regs[6][15:14];
		slot_b.float_led_choice = regs[7][15:14];
		slot_a.fire_position_mask = regs[15][11:8];
		slot_b.fire_position_mask = regs[15][15:12];
		slot_a.sign_positions_one_two = regs[13][2:1];
		slot_b.sign_positions_one_two = regs[13][6:5];
		slot_a.sign_positions_three_four = regs[13][9:8];
		slot_b.sign_positions_three_four = regs[13][11:10];
		slot_a.cathode_bias_select = regs[12][9:8];
		slot_b.cathode_bias_select = regs[12][11:10];
	end

	// Position within the group of four and the sign choice for it.
	always_comb begin
		position = pulse_index[1:0];
		first_pulse = (pulse_index == 8'h00);
		// Value 2 on a pair subtracts the first of it and adds the second; value 1 the reverse.
		if (position[1] == 1'b0) begin
			subtract_here = (cfg.sign_positions_one_two == 2'h2) ? !position[0] :
				(cfg.sign_positions_one_two == 2'h1) ? position[0] : 1'b0;
		end else begin
			subtract_here = (cfg.sign_positions_three_four == 2'h1) ? position[0] :
				(cfg.sign_positions_three_four == 2'h2) ? !position[0] : 1'b0;
		end
		sample_ext = result_width'(signed'({1'b0, pulse_result}));
		// First float time, clamped at zero when precondition exceeds the dump point.
		first_float_us = 16'(cfg.first_dump_offset) + 16'(cfg.connect_width);
		if (first_float_us > 16'(cfg.precondition_time)) begin
			first_float_us = first_float_us - 16'(cfg.precondition_time);
		end else begin
			first_float_us = 16'h0000;
		end
	end

	// Sequencer: precondition, then float/connect per pulse, accumulate, one write.
	always_comb begin
		next_state = state;
		next_cfg = cfg;
		next_timer = timer;
		next_pulse_index = pulse_index;
		next_accum = accum;
		next_led_fire = 3'h0;
		next_result_valid = 1'b0;
		next_result_slot_b = result_slot;
		if (timer != 16'h0000) begin
			next_timer = timer - 16'h0001;
		end
		case (state)
			float_led_pkg::st_idle: begin
				if (sample_start) begin
					next_cfg = slot_b_select ? slot_b : slot_a;
					next_result_slot_b = slot_b_select;
					next_accum = '0;
					next_pulse_index = 8'h00;
					if (next_cfg.source == float_led_pkg::float_source &&
						next_cfg.float_enable == float_led_pkg::float_enabled &&
						next_cfg.pulse_count != 8'h00) begin
						next_state = float_led_pkg::st_precondition;
						next_timer = 16'(next_cfg.precondition_time * float_led_pkg::cycles_per_us);
					end
				end
			end
			float_led_pkg::st_precondition: begin
				if (timer == 16'h0000) begin
					next_state = float_led_pkg::st_float;
					next_timer = 16'(first_float_us * float_led_pkg::cycles_per_us);
				end
			end
			float_led_pkg::st_float: begin
				// LED drive for this interval is set below from the next state.
				if (timer == 16'h0000) begin
					next_state = float_led_pkg::st_connect;
					next_timer = 16'(cfg.connect_width * float_led_pkg::cycles_per_us);
				end
			end
			float_led_pkg::st_connect: begin
				if (timer == 16'h0000) begin
					next_state = float_led_pkg::st_accumulate;
				end
			end
			float_led_pkg::st_accumulate: begin
				next_accum = subtract_here ? accum - sample_ext : accum + sample_ext;
				next_pulse_index = pulse_index + 8'h01;
				if (next_pulse_index >= cfg.pulse_count) begin
					next_state = float_led_pkg::st_write;
				end else begin
					next_state = float_led_pkg::st_float;
					next_timer = 16'(cfg.float_period * float_led_pkg::cycles_per_us);
				end
			end
			float_led_pkg::st_write: begin
				next_result_valid = 1'b1;
				next_state = float_led_pkg::st_idle;
			end
			default: begin
				next_state = float_led_pkg::st_idle;
			end
		endcase
		// The selected LED is lit through the float interval of firing positions.
		if (next_state == float_led_pkg::st_float && cfg.float_led_choice != 2'h0) begin
			if (!cfg.fire_position_mask[next_pulse_index[1:0]]) begin
				next_led_fire = 3'h1 << (cfg.float_led_choice - 2'h1);
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state <= float_led_pkg::st_idle;
			cfg <= '0;
			timer <= 16'h0000;
			pulse_index <= 8'h00;
			accum <= '0;
			led_fire <= 3'h0;
			result_valid <= 1'b0;
			result_slot <= 1'b0;
			result_data <= '0;
		end else begin
			state <= next_state;
			cfg <= next_cfg;
			timer <= next_timer;
			pulse_index <= next_pulse_index;
			accum <= next_accum;
			led_fire <= next_led_fire;
			result_valid <= next_result_valid;
			result_slot <= next_result_slot_b;
			if (next_result_valid) begin
				result_data <= accum;
			end
		end
	end

	// Analog path controls decoded from state; cathode override comes straight from its register bit.
	assign pd_connect = (state == float_led_pkg::st_connect);
	assign pd_precondition = (state == float_led_pkg::st_precondition);
	assign integrate_strobe = (state == float_led_pkg::st_accumulate);
	assign busy = (state != float_led_pkg::st_idle);
	assign result_slot_b = result_slot;
	assign cathode_override = regs[12][7];
	// Per-slot bias applies only while preconditioning under override.
	assign cathode_bias = (pd_precondition && cathode_override) ? cfg.cathode_bias_select : 2'h0;
endmodule : float_led_pulse_sequencer

// ===== float_led_pkg.sv
// Package with register map, field layout and timing constants for the float LED sequencer.
package float_led_pkg;
	localparam logic [7:0] addr_source_select = 8'h14;
	localparam logic [7:0] addr_a_pulse_timing = 8'h30;
	localparam logic [7:0] addr_a_period_low = 8'h31;
	localparam logic [7:0] addr_b_pulse_timing = 8'h35;
	localparam logic [7:0] addr_b_period_low = 8'h36;
	localparam logic [7:0] addr_period_high = 8'h37;
	localparam logic [7:0] addr_a_led_choice = 8'h3E;
	localparam logic [7:0] addr_b_led_choice = 8'h3F;
	localparam logic [7:0] addr_a_amp_reference = 8'h42;
	localparam logic [7:0] addr_a_analog_cfg = 8'h43;
	localparam logic [7:0] addr_b_amp_reference = 8'h44;
	localparam logic [7:0] addr_b_analog_cfg = 8'h45;
	localparam logic [7:0] addr_cathode_bias = 8'h54;
	localparam logic [7:0] addr_sign_control = 8'h58;
	localparam logic [7:0] addr_b_float_control = 8'h59;
	localparam logic [7:0] addr_fire_mask = 8'h5A;
	localparam logic [7:0] addr_a_float_control = 8'h5E;
	localparam logic [15:0] reg_reset = 16'h0000;
	localparam logic [1:0] float_source = 2'h0;
	localparam logic [1:0] float_enabled = 2'h3;
	localparam logic [1:0] cathode_preconditioning = 2'h2;
	localparam int cycles_per_us = 100;
	typedef enum logic [2:0] {
		st_idle,
		st_precondition,
		st_float,
		st_connect,
		st_accumulate,
		st_write
	} seq_state_type;
	// Per-slot settings gathered from the register file.
	typedef struct packed {
		logic [1:0] source;
		logic [1:0] float_enable;
		logic [4:0] precondition_time;
		logic [9:0] float_period;
		logic [4:0] connect_width;
		logic [7:0] first_dump_offset;
		logic [7:0] pulse_count;
		logic [1:0] float_led_choice;
		logic [3:0] fire_position_mask;
		logic [1:0] sign_positions_one_two;
		logic [1:0] sign_positions_three_four;
		logic [1:0] cathode_bias_select;
	} slot_cfg_type;
endpackage : float_led_pkg

// ===== float_led_chk.sv
// Checker of output timing for the float LED sequencer.
`timescale 1ns/1ps
module float_led_chk #(
	parameter int result_width = 27
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [2:0] led_fire,
	input wire logic pd_connect,
	input wire logic pd_precondition,
	input wire logic [1:0] cathode_bias,
	input wire logic cathode_override,
	input wire logic integrate_strobe,
	input wire logic busy,
	input wire logic result_valid,
	input wire logic signed [result_width-1:0] result_data
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	// Result and strobe pulses, phase exclusion and bias gating.
	a_result_one_cycle: assert property (result_valid |=> !result_valid)
		else $error("result_valid too long");
	a_result_held: assert property (!result_valid |-> $stable(result_data))
		else $error("result_data moved without result_valid");
	a_led_in_float: assert property (|led_fire |-> !pd_connect && !pd_precondition)
		else $error("LED lit outside float");
	a_led_one_hot: assert property ($onehot0(led_fire))
		else $error("more than one LED lit");
	a_strobe_after_dump: assert property (integrate_strobe |-> $past(pd_connect) && !pd_connect)
		else $error("strobe not right after connect");
	a_strobe_one_cycle: assert property (integrate_strobe |=> !integrate_strobe)
		else $error("strobe too long");
	a_idle_quiet: assert property (!busy |-> !led_fire && !pd_connect && !integrate_strobe)
		else $error("activity while idle");
	a_bias_in_precon: assert property (|cathode_bias |-> pd_precondition && cathode_override)
		else $error("cathode bias outside precondition");
	a_precon_first: assert property ($rose(busy) |-> pd_precondition)
		else $error("sample did not open with precondition");
	// Main scenarios reached.
	c_result: cover property (result_valid);
	c_led: cover property (|led_fire);
	c_bias: cover property (|cathode_bias);
endmodule : float_led_chk

bind float_led_pulse_sequencer float_led_chk #(.result_width(result_width)) u_chk (
	.clock, .reset_n, .led_fire, .pd_connect, .pd_precondition, .cathode_bias,
	.cathode_override, .integrate_strobe, .busy, .result_valid, .result_data
);

// ===== float_led_front.sv
// Model of the photodiode and integrator path facing the sequencer.
`timescale 1ns/1ps
module float_led_front #(
	parameter int sample_width = 14
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [2:0] led_fire,
	input wire logic integrate_strobe,
	output logic [sample_width-1:0] pulse_result
);
	logic lit;
	logic [sample_width-1:0] last;
	// A pulse whose float saw the LED carries its return on top of ambient and offset.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			lit <= 1'b0;
			last <= '0;
		end else begin
			if (integrate_strobe)
				lit <= 1'b0;
			else if (|led_fire)
				lit <= 1'b1;
			last <= pulse_result;
		end
	end
	// Outside the strobe cycle the line shows a changing pattern, never a stale value.
	assign pulse_result = integrate_strobe ? sample_width'(lit ? 16'h0096 : 16'h0064) : ~last;
endmodule : float_led_front

// ===== tb.sv
// Self-checking bench for the float LED sequencer.
`timescale 1ns/1ps
module tb;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic reg_write = 1'b0;
	logic [7:0] reg_address = 8'h00;
	logic [15:0] reg_write_data = 16'h0000;
	logic sample_start = 1'b0;
	logic slot_b_select = 1'b0;
	logic [13:0] pulse_result;
	logic [15:0] reg_read_data;
	logic [2:0] led_fire;
	logic pd_connect;
	logic pd_precondition;
	logic [1:0] cathode_bias;
	logic cathode_override;
	logic integrate_strobe;
	logic busy;
	logic result_valid;
	logic result_slot_b;
	logic signed [26:0] result_data;
	logic [2:0] led_seen;
	logic [1:0] cb;
	int n_fail = 0;
	int checked = 0;
	int lit_cyc, conn_cyc, pre_cyc, k;
	// Columns: slot, fire mask, sign 1/2, sign 3/4, pulses, LED choice, lit pulses, result.
	int rows [6][8] = '{'{0, 9, 2, 1, 4, 1, 2, 100}, '{1, 9, 2, 1, 8, 2, 4, 200},
		'{0, 15, 0, 0, 2, 3, 0, 200}, '{1, 6, 1, 2, 4, 3, 2, 100},
		'{0, 0, 1, 0, 6, 1, 6, 300}, '{1, 9, 2, 1, 4, 0, 0, 0}};
	float_led_pulse_sequencer dut (.clock, .reset_n, .reg_write, .reg_address, .reg_write_data,
		.reg_read_data, .sample_start, .slot_b_select, .pulse_result, .led_fire, .pd_connect,
		.pd_precondition, .cathode_bias, .cathode_override, .integrate_strobe, .busy,
		.result_valid, .result_slot_b, .result_data);
	float_led_front front (.clock, .reset_n, .led_fire, .integrate_strobe, .pulse_result);
	// Clock of 10 ns period.
	initial begin
		forever #5 clock = ~clock;
	end
	task automatic test_done;
		if (n_fail == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done
	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s expected %0h seen %0h", name, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_address <= a;
		reg_write_data <= d;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clock);
		reg_write <= 1'b0;
		reg_address <= a;
		#1 chk("reg_read_data", 32'(e), 32'(reg_read_data));
	endtask : rd
	// Program one slot from a row; the analog settings are the float LED ones.
	task automatic cfg(input int r[8]);
		wr(8'h14, 16'h0000);
		wr(r[0] ? 8'h59 : 8'h5E, 16'h6100);
		wr(r[0] ? 8'h35 : 8'h30, 16'h0101);
		wr(r[0] ? 8'h36 : 8'h31, {r[4][7:0], 8'h01});
		wr(8'h37, 16'h0000);
		wr(r[0] ? 8'h3F : 8'h3E, {r[5][1:0], 14'h0000});
		wr(8'h5A, 16'(r[1]) << (r[0] ? 12 : 8));
		wr(8'h58, r[0] ? {4'h0, r[3][1:0], 3'h0, r[2][1:0], 5'h00}
			: {6'h00, r[3][1:0], 5'h00, r[2][1:0], 1'h0});
		wr(8'h54, 16'h0A80);
		wr(r[0] ? 8'h45 : 8'h43, 16'hAE65);
		wr(r[0] ? 8'h44 : 8'h42, 16'h0020);
	endtask : cfg
	// Start a sample and watch the phases until the result appears.
	task automatic run(input logic b);
		int i;
		@(posedge clock);
		reg_write <= 1'b0;
		sample_start <= 1'b1;
		slot_b_select <= b;
		@(posedge clock);
		sample_start <= 1'b0;
		lit_cyc = 0;
		conn_cyc = 0;
		pre_cyc = 0;
		led_seen = 3'h0;
		cb = 2'h0;
		for (i = 0; i < 4000; i++) begin
			#1;
			if (result_valid === 1'b1)
				break;
			lit_cyc += int'(|led_fire);
			conn_cyc += int'(pd_connect);
			pre_cyc += int'(pd_precondition);
			if (|led_fire)
				led_seen = led_fire;
			if (pd_precondition)
				cb = cathode_bias;
			@(posedge clock);
		end
		if (i == 4000) begin
			chk("result_valid", 1, 32'(result_valid));
			test_done();
		end
	endtask : run
	initial begin
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		rd(8'h58, 16'h0000);
		rd(8'h5A, 16'h0000);
		for (k = 0; k < 6; k++) begin
			cfg(rows[k]);
			run(rows[k][0]);
			chk("result_data", rows[k][7], 32'(result_data));
			chk("result_slot_b", rows[k][0], 32'(result_slot_b));
			chk("led_fire", rows[k][6] ? 1 << (rows[k][5] - 1) : 0, 32'(led_seen));
			chk("lit_cycles", rows[k][6] * 101, lit_cyc);
			chk("connect_cycles", rows[k][4] * 101, conn_cyc);
			chk("precondition_cycles", 101, pre_cyc);
			chk("cathode_bias", 2, 32'(cb));
		end
		// A start while busy is ignored: slot A finishes untouched.
		cfg(rows[0]);
		run(1'b0);
		@(posedge clock);
		sample_start <= 1'b1;
		@(posedge clock);
		sample_start <= 1'b0;
		repeat (20) @(posedge clock);
		run(1'b1);
		chk("result_data", 100, 32'(result_data));
		chk("result_slot_b", 0, 32'(result_slot_b));
		@(posedge clock);
		#1 chk("busy", 0, 32'(busy));
		// A slot whose source is not zero does not start.
		wr(8'h14, 16'h0005);
		@(posedge clock);
		reg_write <= 1'b0;
		sample_start <= 1'b1;
		@(posedge clock);
		sample_start <= 1'b0;
		@(posedge clock);
		#1 chk("busy", 0, 32'(busy));
		wr(8'h37, 16'h0302);
		rd(8'h37, 16'h0302);
		wr(8'h37, 16'h0000);
		wr(8'h00, 16'hFFFF);
		rd(8'h00, 16'h0000);
		// Reset in mid-sample clears state and registers.
		wr(8'h14, 16'h0000);
		run(1'b1);
		sample_start <= 1'b1;
		repeat (50) @(posedge clock);
		reset_n <= 1'b0;
		sample_start <= 1'b0;
		rd(8'h58, 16'h0000);
		chk("busy", 0, 32'(busy));
		// After release the sequencer stays idle until a new start.
		reset_n <= 1'b1;
		repeat (2) @(posedge clock);
		#1 chk("busy", 0, 32'(busy));
		test_done();
	end
endmodule : tb
